/* File: timer16_pkg.sv */
// Constants, register map and carrier types of the 16-bit counter/capture.
// Assumes an 8-bit I/O location bus on the system clock and a prescaler
// outside that delivers timer tick enables.
//
// Operation
// - Counter appears as two byte locations: upper byte and lower byte.
// - Upper location hits latch; lower read fills it, lower write uses it.
// - One latched upper byte may serve several following lower-byte writes.
// - Three-bit source select picks the tick; code zero halts counting.
// - Each tick clears, increments or decrements per mode and direction.
// - Floor indication at zero, ceiling indication at top of sequence.
// - Counter is readable and writable whether or not ticks run.
// - CPU counter write beats clear or count in the same cycle.
// - Four-bit mode field: upper two bits in B, lower two in A.
// - Overflow flag set where the mode says; usable as interrupt.
// - Capture trigger comes from capture pin or comparator output.
// - Matching edge copies counter to capture value; flag sets same cycle.
// - Capture flag with enable bit one raises a capture interrupt request.
// - Capture flag clears when its interrupt is serviced.
// - Writing one to capture flag clears it; zero leaves it.
// - Capture lower read first loads its upper byte into the latch.
// - Capture value writable only in modes using it as ceiling.
// - One latch shared by all 16-bit registers of the timer.
// - Filter output changes after four equal samples; five cycles delay.
// - Switching trigger source may cause a capture; software clears flag.
package timer16_pkg;

  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;

  // Location offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL_A = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL_B = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_TRIG = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_CAP_LO = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CAP_HI = 4'h9;

  // Field positions
  localparam int WGM_LO_POS = 0;
  localparam int CS_POS = 0;
  localparam int WGM_HI_POS = 3;
  localparam int EDGE_POS = 6;
  localparam int FILT_POS = 7;
  localparam int TRIG_SEL_POS = 6;
  localparam int OVF_POS = 0;
  localparam int CAP_POS = 5;

  // Reset values and the fixed counter maximum
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // Filter window in system clock samples
  localparam int FILT_LEN = 4;

  // Modes that take the capture value as ceiling; the first two are dual slope
  localparam logic [3:0] MODE_CAP_DUAL_A = 4'h8;
  localparam logic [3:0] MODE_CAP_DUAL_B = 4'hA;
  localparam logic [3:0] MODE_CAP_CLEAR = 4'hC;
  localparam logic [3:0] MODE_CAP_FAST = 4'hE;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_t;

endpackage

/* File: timer16_capture.sv */
// 16-bit counter with tick select, overflow flag and input capture.
// Assumes tick_src pulses are one-cycle enables on clk; capture_pin and
// comparator_out are asynchronous and get synchronised here.
`timescale 1ns/1ns
`default_nettype none
module timer16_capture
  import timer16_pkg::*;
#(
  parameter int TICK_N = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire io_req_t io,
  output logic [7:0] rdata,
  input wire logic [TICK_N-1:0] tick_src,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic overflow_ack,
  input wire logic capture_ack,
  output logic overflow_irq,
  output logic capture_irq,
  output logic count_floor,
  output logic count_ceiling,
  output logic count_down,
  output logic [3:0] waveform_mode_sel
);

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [7:0] ctrl_a_q, ctrl_b_q, trig_q, mask_q;
  logic [2:0] cs;
  logic edge_rise, filt_en, trig_cmp;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_a_q <= CTRL_RST;
      ctrl_b_q <= CTRL_RST;
      trig_q <= CTRL_RST;
      mask_q <= CTRL_RST;
    end else if (io.wr) begin
      case (io.addr)
        OFF_CTRL_A: ctrl_a_q <= io.wdata;
        OFF_CTRL_B: ctrl_b_q <= io.wdata;
        OFF_TRIG: trig_q <= io.wdata;
        OFF_MASK: mask_q <= io.wdata;
        default: ;
      endcase
    end
  end

  assign waveform_mode_sel = {ctrl_b_q[WGM_HI_POS +: 2],
                              ctrl_a_q[WGM_LO_POS +: 2]};
  assign cs = ctrl_b_q[CS_POS +: 3];
  assign edge_rise = ctrl_b_q[EDGE_POS];
  assign filt_en = ctrl_b_q[FILT_POS];
  assign trig_cmp = trig_q[TRIG_SEL_POS];

  logic cap_top, dual;
  assign dual = (waveform_mode_sel == MODE_CAP_DUAL_A) ||
                (waveform_mode_sel == MODE_CAP_DUAL_B);
  assign cap_top = dual || (waveform_mode_sel == MODE_CAP_CLEAR) ||
                   (waveform_mode_sel == MODE_CAP_FAST);

  //////////////////////////////////////////////////////////////////////////
  // Tick select

  logic tick;
  always_comb begin
    tick = 1'b0;
    if (cs != 3'h0 && int'(cs) <= TICK_N) begin
      tick = tick_src[cs - 3'h1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Byte access decode and the shared upper-byte latch

  logic cnt_lo_wr, cnt_lo_rd, cap_lo_wr, cap_lo_rd, hi_wr;
  assign cnt_lo_wr = io.wr && io.addr == OFF_CNT_LO;
  assign cnt_lo_rd = io.rd && io.addr == OFF_CNT_LO;
  assign cap_lo_wr = io.wr && io.addr == OFF_CAP_LO;
  assign cap_lo_rd = io.rd && io.addr == OFF_CAP_LO;
  assign hi_wr = io.wr && (io.addr == OFF_CNT_HI || io.addr == OFF_CAP_HI);

  logic [7:0] temp_q;
  logic [CNT_W-1:0] cnt_q, cap_q;

  // One latch for every wide register, so accesses disturb each other
  always_ff @(posedge clk) begin
    if (!nrst) begin
      temp_q <= 8'h00;
    end else if (hi_wr) begin
      temp_q <= io.wdata;
    end else if (cnt_lo_rd) begin
      temp_q <= cnt_q[15:8];
    end else if (cap_lo_rd) begin
      temp_q <= cap_q[15:8];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter unit

  dir_t dir_q;
  logic [CNT_W-1:0] top;
  assign top = cap_top ? cap_q : CNT_MAX;
  assign count_floor = cnt_q == CNT_RST;
  assign count_ceiling = cnt_q == top;
  assign count_down = dir_q == DIR_DOWN;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= CNT_RST;
    end else if (cnt_lo_wr) begin
      cnt_q <= {temp_q, io.wdata};
    end else if (tick) begin
      if (!dual) begin
        cnt_q <= count_ceiling ? CNT_RST : cnt_q + 16'h0001;
      end else if (dir_q == DIR_UP) begin
        cnt_q <= count_ceiling ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end else begin
        cnt_q <= count_floor ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_q <= DIR_UP;
    end else if (!dual) begin
      dir_q <= DIR_UP;
    end else if (tick && !cnt_lo_wr) begin
      if (dir_q == DIR_UP && count_ceiling) begin
        dir_q <= DIR_DOWN;
      end else if (dir_q == DIR_DOWN && count_floor) begin
        dir_q <= DIR_UP;
      end
    end
  end

  // Single slope overflows on wrap at the ceiling, dual slope at the floor
  logic ovf_set;
  assign ovf_set = tick && !cnt_lo_wr &&
                   (dual ? (dir_q == DIR_DOWN && count_floor)
                         : count_ceiling);

  //////////////////////////////////////////////////////////////////////////
  // Capture input: sync, filter, edge detect

  logic [1:0] s1_q, s2_q, s3_q, clean_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      clean_q <= 2'h0;
    end else begin
      s1_q <= {comparator_out, capture_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 2; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Source switch can itself look like an edge
  logic src;
  assign src = trig_cmp ? clean_q[1] : clean_q[0];

  logic [FILT_LEN-1:0] filt_sh_q;
  logic filt_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      filt_sh_q <= '0;
      filt_q <= 1'b0;
    end else begin
      filt_sh_q <= {filt_sh_q[FILT_LEN-2:0], src};
      if (&filt_sh_q || ~|filt_sh_q) begin
        filt_q <= filt_sh_q[0];
      end
    end
  end

  logic det_in, prev_q, cap_evt;
  assign det_in = filt_en ? filt_q : src;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= det_in;
    end
  end

  // Detector is off while the capture value serves as ceiling
  assign cap_evt = !cap_top && (det_in != prev_q) &&
                   (det_in == edge_rise);

  //////////////////////////////////////////////////////////////////////////
  // Capture value

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_q <= CNT_RST;
    end else if (cap_evt) begin
      cap_q <= cnt_q;
    end else if (cap_lo_wr && cap_top) begin
      cap_q <= {temp_q, io.wdata};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags; a set in the clearing cycle wins

  logic ovf_flag_q, cap_flag_q, flag_wr;
  assign flag_wr = io.wr && io.addr == OFF_FLAGS;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_flag_q <= 1'b0;
    end else if (cap_evt) begin
      cap_flag_q <= 1'b1;
    end else if (capture_ack) begin
      cap_flag_q <= 1'b0;
    end else if (flag_wr && io.wdata[CAP_POS]) begin
      cap_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovf_flag_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag_q <= 1'b1;
    end else if (overflow_ack || (flag_wr && io.wdata[OVF_POS])) begin
      ovf_flag_q <= 1'b0;
    end
  end

  assign capture_irq = cap_flag_q && mask_q[CAP_POS];
  assign overflow_irq = ovf_flag_q && mask_q[OVF_POS];

  //////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read strobe

  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    case (io.addr)
      OFF_CTRL_A: rdata_d = ctrl_a_q;
      OFF_CTRL_B: rdata_d = ctrl_b_q;
      OFF_TRIG: rdata_d = trig_q;
      OFF_MASK: rdata_d = mask_q;
      OFF_FLAGS: begin
        rdata_d[CAP_POS] = cap_flag_q;
        rdata_d[OVF_POS] = ovf_flag_q;
      end
      OFF_CNT_LO: rdata_d = cnt_q[7:0];
      OFF_CAP_LO: rdata_d = cap_q[7:0];
      OFF_CNT_HI: rdata_d = temp_q;
      OFF_CAP_HI: rdata_d = temp_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (io.rd) begin
      rdata <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_write_priority: assert property (
    cnt_lo_wr |=> cnt_q == {$past(temp_q), $past(io.wdata)})
    else $error("counter write did not take priority");

  a_halt_stopped: assert property (
    cs == 3'h0 && !cnt_lo_wr |=> $stable(cnt_q))
    else $error("counter moved with no tick source");

  a_count_up: assert property (
    tick && !dual && !cnt_lo_wr && !count_ceiling
      |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not increment on tick");

  a_dir_turn: assert property (
    dual && tick && !cnt_lo_wr && !count_down && count_ceiling
      |=> count_down)
    else $error("dual slope did not turn at the ceiling");

  a_latch_fill: assert property (
    cnt_lo_rd && !hi_wr |=> temp_q == $past(cnt_q[15:8]))
    else $error("latch not loaded by counter low read");

  a_latch_cap: assert property (
    cap_lo_rd && !hi_wr |=> temp_q == $past(cap_q[15:8]))
    else $error("latch not loaded by capture low read");

  a_capture_copy: assert property (
    cap_evt |=> cap_q == $past(cnt_q) && cap_flag_q)
    else $error("capture did not copy counter and set flag");

  a_flag_clear: assert property (
    flag_wr && io.wdata[CAP_POS] && !cap_evt |=> !cap_flag_q)
    else $error("capture flag not cleared by one");

  a_flag_keep: assert property (
    flag_wr && !io.wdata[CAP_POS] && !capture_ack
      |=> cap_flag_q == $past(cap_flag_q) || $past(cap_evt))
    else $error("capture flag changed by zero write");

  a_ack_clear: assert property (
    capture_ack && !cap_evt |=> !cap_flag_q)
    else $error("capture flag not cleared by service");

  a_irq_request: assert property (
    cap_evt && mask_q[CAP_POS] ##1 mask_q[CAP_POS] |-> capture_irq)
    else $error("capture interrupt missing");

  a_cap_wr_gate: assert property (
    cap_lo_wr && !cap_top && !cap_evt |=> $stable(cap_q))
    else $error("capture value written outside ceiling mode");

  a_ceiling_hold: assert property (
    cap_top && !cap_lo_wr |=> $stable(cap_q))
    else $error("capture value moved in a ceiling mode");

  a_ovf_set: assert property (
    ovf_set |=> ovf_flag_q)
    else $error("overflow flag not set");

  a_filter_hold: assert property (
    !(&filt_sh_q) && |filt_sh_q |=> $stable(filt_q))
    else $error("filter changed without four equal samples");

  c_capture: cover property (cap_evt ##1 capture_irq);
  c_overflow: cover property (ovf_set ##1 ovf_flag_q);
  c_dual_turn: cover property (dual && tick && count_ceiling ##1 count_down);
  c_flag_clear: cover property (cap_flag_q && flag_wr ##1 !cap_flag_q);

endmodule
`default_nettype wire

/* File: event_source.sv */
// Far-side model of the capture inputs: the pin and the comparator output.
// Assumes the bench commands the levels; edges land off the clock edge,
// at a fixed 13 ns after each rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module event_source (
  input wire logic clk,
  input wire logic pin_lvl,
  input wire logic cmp_lvl,
  output logic capture_pin,
  output logic comparator_out
);
  initial begin
    capture_pin = 1'b0;
    comparator_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Odd skew keeps the change clear of the sampling edge
  always @(posedge clk) begin
    #13;
    capture_pin = pin_lvl;
    comparator_out = cmp_lvl;
  end
endmodule
`default_nettype wire

/* File: sixteen_bit_counter_capture_test.sv */
// Self-checking bench for the 16-bit counter with input capture.
// Assumes timer16_pkg and timer16_capture are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sixteen_bit_counter_capture_test;
  import timer16_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  io_req_t io = '0;
  logic [6:0] tick_src = '0;
  logic overflow_ack = 1'b0;
  logic capture_ack = 1'b0;
  logic pin_lvl = 1'b0;
  logic cmp_lvl = 1'b0;
  logic capture_pin, comparator_out, overflow_irq, capture_irq;
  logic count_floor, count_ceiling, count_down;
  logic [3:0] waveform_mode_sel;
  logic [7:0] rdata;
  logic rd_p = 1'b0;
  logic [7:0] exp_q[$];
  int errors = 0;
  int n_checks = 0;
  int seed = 24;
  int n;
  always #25 clk = ~clk;
  timer16_capture timer16_capture_inst (.clk(clk), .nrst(nrst), .io(io),
    .rdata(rdata), .tick_src(tick_src), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .overflow_ack(overflow_ack),
    .capture_ack(capture_ack), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq), .count_floor(count_floor),
    .count_ceiling(count_ceiling), .count_down(count_down),
    .waveform_mode_sel(waveform_mode_sel));
  event_source event_source_inst (.clk(clk), .pin_lvl(pin_lvl),
    .cmp_lvl(cmp_lvl), .capture_pin(capture_pin),
    .comparator_out(comparator_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus strobes last one cycle; an idle cycle follows each access
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) io <= '{a, 1'b1, 1'b0, d};
    @(posedge clk) io <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk) io <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk) io <= '0;
  endtask
  // Upper byte first on writes, lower byte first on reads
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, input logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask
  task automatic tick(input int k);
    @(posedge clk) tick_src <= 7'h01 << k;
    @(posedge clk) tick_src <= '0;
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 30 && capture_irq !== 1'b1; i++) @(negedge clk);
    if (capture_irq !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask
  task automatic no_irq();
    repeat (20) @(negedge clk);
    check("capture_irq", 16'h0000, 16'(capture_irq));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: a read strobe seen at one edge has its data at the next
  always @(posedge clk) begin
    if (rd_p) begin
      check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    end
    rd_p <= io.rd;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  // No interrupt code runs here, so two-byte accesses stay atomic
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("count_floor", 16'h0001, 16'(count_floor));
    check("count_down", 16'h0000, 16'(count_down));
    rd16(OFF_CNT_LO, 16'h0000);
    rd(OFF_CTRL_B, 8'h00);
    wr16(OFF_CNT_LO, 16'h01FF);
    rd16(OFF_CNT_LO, 16'h01FF);
    @(negedge clk);
    check("count_floor", 16'h0000, 16'(count_floor));
    wr(4'hF, 8'h55);
    rd(4'hF, 8'h00);
    wr(OFF_CTRL_B, 8'h18);
    wr(OFF_CTRL_A, 8'h02);
    @(negedge clk);
    check("mode", 16'h000E, 16'(waveform_mode_sel));
    wr(OFF_CAP_HI, 8'h05);
    wr(OFF_CAP_LO, 8'h34);
    wr(OFF_CNT_LO, 8'h00);
    rd16(OFF_CAP_LO, 16'h0534);
    rd16(OFF_CNT_LO, 16'h0500);
    wr16(OFF_CNT_LO, 16'h0534);
    @(negedge clk);
    check("count_ceiling", 16'h0001, 16'(count_ceiling));
    wr(OFF_CTRL_A, 8'h00);
    wr(OFF_CTRL_B, 8'h00);
    wr16(OFF_CAP_LO, 16'h7799);
    rd16(OFF_CAP_LO, 16'h0534);
    // Every source code; an unselected tick must not count
    wr16(OFF_CNT_LO, 16'h0000);
    for (int k = 1; k < 8; k++) begin
      wr(OFF_CTRL_B, 8'(k));
      tick(k - 1);
      tick(k % 7);
    end
    wr(OFF_CTRL_B, 8'h00);
    tick(0);
    rd16(OFF_CNT_LO, 16'h0007);
    n = ($random(seed) & 15) + 1;
    wr(OFF_CTRL_B, 8'h01);
    repeat (n) tick(0);
    rd16(OFF_CNT_LO, 16'(7 + n));
    wr(OFF_CNT_HI, 8'h00);
    @(posedge clk) begin
      io <= '{OFF_CNT_LO, 1'b1, 1'b0, 8'h40};
      tick_src <= 7'h01;
    end
    @(posedge clk) begin
      io <= '0;
      tick_src <= '0;
    end
    rd16(OFF_CNT_LO, 16'h0040);
    wr16(OFF_CNT_LO, 16'hFFFF);
    wr(OFF_MASK, 8'h21);
    tick(0);
    @(negedge clk);
    check("overflow_irq", 16'h0001, 16'(overflow_irq));
    rd16(OFF_CNT_LO, 16'h0000);
    @(posedge clk) overflow_ack <= 1'b1;
    @(posedge clk) overflow_ack <= 1'b0;
    @(negedge clk);
    check("overflow_irq", 16'h0000, 16'(overflow_irq));
    // Capture on the pin, rising edge, counter halted at a known value
    wr(OFF_CTRL_B, 8'h40);
    wr16(OFF_CNT_LO, 16'h1234);
    pin_lvl <= 1'b1;
    wait_irq();
    rd16(OFF_CAP_LO, 16'h1234);
    wr(OFF_FLAGS, 8'h00);
    rd(OFF_FLAGS, 8'h20);
    wr(OFF_FLAGS, 8'h20);
    @(negedge clk);
    check("capture_irq", 16'h0000, 16'(capture_irq));
    pin_lvl <= 1'b0;
    no_irq();
    wr(OFF_CTRL_B, 8'h00);
    pin_lvl <= 1'b1;
    no_irq();
    pin_lvl <= 1'b0;
    wait_irq();
    @(posedge clk) capture_ack <= 1'b1;
    @(posedge clk) capture_ack <= 1'b0;
    @(negedge clk);
    check("capture_irq", 16'h0000, 16'(capture_irq));
    // Comparator source, masked; the switch itself may capture
    wr(OFF_MASK, 8'h00);
    wr16(OFF_CNT_LO, 16'h0ABC);
    pin_lvl <= 1'b1;
    cmp_lvl <= 1'b1;
    wr(OFF_TRIG, 8'h40);
    repeat (10) @(posedge clk);
    wr(OFF_FLAGS, 8'h20);
    cmp_lvl <= 1'b0;
    no_irq();
    rd(OFF_FLAGS, 8'h20);
    rd16(OFF_CAP_LO, 16'h0ABC);
    // Filtered pin: a two-cycle glitch is ignored, a held level is not
    wr(OFF_MASK, 8'h20);
    wr(OFF_TRIG, 8'h00);
    wr(OFF_CTRL_B, 8'h80);
    repeat (10) @(posedge clk);
    wr(OFF_FLAGS, 8'h20);
    pin_lvl <= 1'b0;
    repeat (2) @(posedge clk);
    pin_lvl <= 1'b1;
    no_irq();
    pin_lvl <= 1'b0;
    wait_irq();
    // Dual slope with the capture value as ceiling: up to 3, down to 0
    wr(OFF_CTRL_B, 8'h10);
    wr16(OFF_CAP_LO, 16'h0003);
    wr16(OFF_CNT_LO, 16'h0002);
    wr(OFF_CTRL_B, 8'h11);
    repeat (2) tick(0);
    @(negedge clk);
    check("count_down", 16'h0001, 16'(count_down));
    check("count_ceiling", 16'h0000, 16'(count_ceiling));
    repeat (3) tick(0);
    @(negedge clk);
    check("count_down", 16'h0000, 16'(count_down));
    rd(OFF_FLAGS, 8'h21);
    rd16(OFF_CNT_LO, 16'h0001);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
